// File: logic/occ_ctrl.sv
// oscillator control, trim and switch handshake with ahb-lite slave
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "occ_map.svh"
module occ_ctrl
    import occ_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pll_locked,
    input wire logic clock_fail,
    input wire logic switch_ack,
    input wire logic [2:0] pwm_index,
    output logic [2:0] requested_clock_source,
    output logic switch_start,
    output logic random_dither_enable,
    output logic [3:0] frc_trim,
    output logic irq
);
    // ****************************************
    // state
    // ****************************************
    logic [2:0] req_src_reg;
    logic [2:0] act_src_reg;
    logic lock_reg;
    logic dith_reg;
    logic fail_reg;
    logic seq_reg;
    logic swr_reg;
    logic [15:0] trim_reg;
    logic [15:0] trim2_reg;
    logic [`OCC_IRQ_W-1:0] ists_reg;
    logic [`OCC_IRQ_W-1:0] ien_reg;
    logic [3:0] trim_next;
    logic [3:0] frc_trim_reg;
    logic [31:0] rdata_next;
    occ_sw_state_t sw_reg;
    logic wr_pend_reg;
    logic [AW-1:0] wr_addr_reg;
    logic lock_seen_reg;

    // refuse address widths the offset decode cannot serve
    if (AW < 5 || AW > 12) begin : g_bad_aw
        $error("occ_ctrl: address width out of range");
    end

    // ****************************************
    // ahb-lite slave
    // ****************************************
    logic take;
    logic wr_go;
    logic sw_start_ev;
    logic sw_done_ev;
    logic redundant_ev;
    logic pll_sel;
    assign take = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;  // zero wait states
    assign hresp = 1'b0;      // always okay
    assign wr_go = wr_pend_reg & clk_en;

    // decode a write to a given offset
    function automatic logic wr_hit(input logic [AW-1:0] a,
                                    input logic [11:0] ofs);
        wr_hit = (a[AW-1:2] == ofs[AW-1:2]);
    endfunction

    // word index of a register offset, sized like the address decode
    function automatic logic [AW-3:0] widx(input logic [11:0] ofs);
        widx = ofs[AW-1:2];
    endfunction

    // capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else if (clk_en) begin
            wr_pend_reg <= take & hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // read data mux, unmapped reads as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (haddr[AW-1:2])
            widx(`OCC_CTRL_OFS): begin
                rdata_next[`OCC_ACT_LSB +: 3] = act_src_reg;
                rdata_next[`OCC_REQ_LSB +: 3] = req_src_reg;
                // [R3] lock reads zero unless pll source active
                rdata_next[`OCC_LOCK_BIT] = lock_reg & pll_sel;
                rdata_next[`OCC_DITH_BIT] = dith_reg;
                rdata_next[`OCC_FAIL_BIT] = fail_reg;
                rdata_next[`OCC_SEQ_BIT] = seq_reg;
                rdata_next[`OCC_SWR_BIT] = swr_reg;
            end
            widx(`OCC_TRIM_OFS): rdata_next[15:0] = trim_reg;
            widx(`OCC_TRIM2_OFS): rdata_next[15:0] = trim2_reg;
            widx(`OCC_IRQ_STAT_OFS): begin
                rdata_next[`OCC_IRQ_W-1:0] = ists_reg;
            end
            widx(`OCC_IRQ_EN_OFS): rdata_next[`OCC_IRQ_W-1:0] = ien_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // register read data on the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en && take && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    // ****************************************
    // clock switch handshake
    // ****************************************
    assign pll_sel = act_src_reg[0];  // odd codes run through the pll
    assign sw_start_ev = (sw_reg == OCC_SW_IDLE) & swr_reg;
    assign redundant_ev = sw_start_ev & (req_src_reg == act_src_reg);
    assign sw_done_ev = (sw_reg == OCC_SW_WAIT) & switch_ack;
    assign switch_start = (sw_reg == OCC_SW_WAIT);
    assign requested_clock_source = req_src_reg;

    // switch sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_reg <= OCC_SW_IDLE;
        end else if (clk_en) begin
            case (sw_reg)
                OCC_SW_IDLE: begin
                    if (clock_fail) begin
                        sw_reg <= OCC_SW_IDLE;
                    end else if (sw_start_ev && !redundant_ev) begin
                        sw_reg <= OCC_SW_WAIT;
                    end else if (redundant_ev) begin
                        sw_reg <= OCC_SW_DONE;
                    end
                end
                OCC_SW_WAIT: begin
                    if (clock_fail || switch_ack) begin
                        sw_reg <= OCC_SW_DONE;
                    end
                end
                OCC_SW_DONE: sw_reg <= OCC_SW_IDLE;
                default: sw_reg <= OCC_SW_IDLE;
            endcase
        end
    end

    // request bit, set by software, cleared by hardware
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swr_reg <= 1'b0;
        end else if (clk_en) begin
            // [R10] clear on done, redundant or failover
            if (sw_reg == OCC_SW_DONE || clock_fail) begin
                swr_reg <= 1'b0;
            // [R9] software request write
            end else if (wr_go && wr_hit(wr_addr_reg, `OCC_CTRL_OFS)
                         && hwdata[`OCC_SWR_BIT]) begin
                swr_reg <= 1'b1;
            end
        end
    end

    // active source follows completed switch or failover
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_src_reg <= `OCC_SRC_RST;
        end else if (clk_en) begin
            if (clock_fail) begin
                act_src_reg <= `OCC_SRC_RST;
            // [R14] copy requested into active
            end else if (sw_done_ev) begin
                act_src_reg <= req_src_reg;
            end
        end
    end

    // software control bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_src_reg <= `OCC_SRC_RST;
            dith_reg <= 1'b0;
            seq_reg <= 1'b0;
        end else if (clk_en && wr_go
                     && wr_hit(wr_addr_reg, `OCC_CTRL_OFS)) begin
            req_src_reg <= hwdata[`OCC_REQ_LSB +: 3];
            dith_reg <= hwdata[`OCC_DITH_BIT];
            seq_reg <= hwdata[`OCC_SEQ_BIT];
        end
    end
    // [R4] dither enable drives the dither circuit
    assign random_dither_enable = dith_reg;

    // ****************************************
    // lock and failure flags
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_reg <= 1'b0;
            lock_seen_reg <= 1'b0;
        end else if (clk_en) begin
            lock_seen_reg <= pll_locked;
            // [R2] clear on switch start or lock loss
            if (sw_start_ev || !pll_locked) begin
                lock_reg <= 1'b0;
            // [R1] set on lock rising after start
            end else if (pll_locked && !lock_seen_reg) begin
                lock_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_reg <= 1'b0;
        end else if (clk_en) begin
            // [R5] monitor failure sets, winning over clears
            if (clock_fail) begin
                fail_reg <= 1'b1;
            // [R6] switch start or software zero clears
            end else if (sw_start_ev) begin
                fail_reg <= 1'b0;
            end else if (wr_go && wr_hit(wr_addr_reg, `OCC_CTRL_OFS)
                         && !hwdata[`OCC_FAIL_BIT]) begin
                fail_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // trim registers and output
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // [R16] trims start at calibrated zero
            trim_reg <= `OCC_TRIM_RST;
            trim2_reg <= `OCC_TRIM_RST;
        end else if (clk_en && wr_go) begin
            if (wr_hit(wr_addr_reg, `OCC_TRIM_OFS)) begin
                trim_reg <= hwdata[15:0];
            end
            if (wr_hit(wr_addr_reg, `OCC_TRIM2_OFS)) begin
                trim2_reg <= hwdata[15:0];
            end
        end
    end

    occ_trim_sel #(
        .NIB(4)
    ) u_sel (
        .trim_word(trim_reg),
        .trim2_word(trim2_reg),
        .seq_en(seq_reg),
        .index(pwm_index),
        .trim(trim_next)
    );

    // [R12] signed code passed unchanged to the oscillator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frc_trim_reg <= 4'h0;
        end else if (clk_en) begin
            frc_trim_reg <= trim_next;
        end
    end
    assign frc_trim = frc_trim_reg;

    // ****************************************
    // interrupts
    // ****************************************
    logic [`OCC_IRQ_W-1:0] ev;
    logic [`OCC_IRQ_W-1:0] clr;
    always_comb begin
        ev = '0;
        ev[`OCC_IRQ_FAIL] = clock_fail;
        ev[`OCC_IRQ_SWDONE] = (sw_reg == OCC_SW_DONE);
        ev[`OCC_IRQ_LOCK] = pll_locked & ~lock_seen_reg;
        clr = '0;
        if (wr_go && wr_hit(wr_addr_reg, `OCC_IRQ_CLR_OFS)) begin
            clr = hwdata[`OCC_IRQ_W-1:0];
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ists_reg <= '0;
            ien_reg <= '0;
        end else if (clk_en) begin
            ists_reg <= (ists_reg & ~clr) | ev;
            if (wr_go && wr_hit(wr_addr_reg, `OCC_IRQ_EN_OFS)) begin
                ien_reg <= hwdata[`OCC_IRQ_W-1:0];
            end
        end
    end
    assign irq = |(ists_reg & ien_reg);

    // ****************************************
    // assertions
    // ****************************************
    a_lock_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        clk_en && pll_locked && !lock_seen_reg && !sw_start_ev
        |=> lock_reg)
        else $error("lock flag not set on lock");
    a_lock_loss: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
        clk_en && !pll_locked |=> !lock_reg)
        else $error("lock flag kept after lock loss");
    a_lock_read: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
        !pll_sel |-> !rdata_next[`OCC_LOCK_BIT])
        else $error("lock read high with pll not selected");
    a_dither_out: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        random_dither_enable == dith_reg)
        else $error("dither output mismatch");
    a_fail_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
        clk_en && clock_fail |=> fail_reg && act_src_reg == 3'h0)
        else $error("failure flag not set");
    a_fail_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        clk_en && sw_start_ev && !clock_fail |=> !fail_reg)
        else $error("failure flag not cleared on switch");
    a_trim_base: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        clk_en && !seq_reg |=> frc_trim == $past(trim_reg[3:0]))
        else $error("base trim not applied");
    a_trim_seq: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        clk_en && seq_reg && pwm_index == 3'h4
        |=> frc_trim == $past(trim2_reg[3:0]))
        else $error("sequence trim not applied");
    a_swr_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
        clk_en && swr_reg && redundant_ev && !clock_fail
        |=> ##1 !swr_reg)
        else $error("redundant switch left request set");
    a_src_copy: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        clk_en && sw_done_ev && !clock_fail
        |=> act_src_reg == $past(req_src_reg))
        else $error("active source not updated");
    c_switch: cover property (@(posedge hclk) disable iff (!hresetn)
        sw_done_ev);
    c_fail: cover property (@(posedge hclk) disable iff (!hresetn)
        clock_fail && swr_reg);
    c_seq: cover property (@(posedge hclk) disable iff (!hresetn)
        seq_reg && pwm_index == 3'h7);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule

// File: logic/occ_map.svh
// register map, field positions, reset values and rule overview
// Overview of operation
// [R1] lock flag sets when pll locks after start
// [R2] lock flag clears on reset, switch, lock loss
// [R3] lock flag reads zero unless pll selected
// [R4] dither bit enables pseudo-random clock dither
// [R5] failure flag sets on monitor clock failure
// [R6] software clears failure flag; switch clears too
// [R7] sequencer picks trim by pwm index
// [R8] sequencer off: base trim only
// [R9] software requests switch; zero means finished
// [R10] request clears on switch done or failover
// [R11] trim register upper nibbles hold trims 3..1
// [R12] base trim is signed frequency code
// [R13] indices four to seven use second register
// [R14] successful switch copies requested to active source
// [R15] index zero selects base trim
// [R16] trims reset to zero, calibrated frequency
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OCC_CTRL_OFS 12'h000
`define OCC_TRIM_OFS 12'h004
`define OCC_TRIM2_OFS 12'h008
`define OCC_IRQ_STAT_OFS 12'h00c
`define OCC_IRQ_EN_OFS 12'h010
`define OCC_IRQ_CLR_OFS 12'h014
// ****************************************
// control field positions
// ****************************************
`define OCC_ACT_LSB 12
`define OCC_REQ_LSB 8
`define OCC_LOCK_BIT 5
`define OCC_DITH_BIT 4
`define OCC_FAIL_BIT 3
`define OCC_SEQ_BIT 2
`define OCC_SWR_BIT 0
// ****************************************
// interrupt status bits
// ****************************************
`define OCC_IRQ_FAIL 0
`define OCC_IRQ_SWDONE 1
`define OCC_IRQ_LOCK 2
`define OCC_IRQ_W 3
// reset values
`define OCC_TRIM_RST 16'h0000
`define OCC_SRC_RST 3'h0
`endif

// File: logic/occ_pkg.sv
// types shared by the oscillator control block
package occ_pkg;
    typedef enum logic [1:0] {
        OCC_SW_IDLE = 2'b00,
        OCC_SW_WAIT = 2'b01,
        OCC_SW_DONE = 2'b10
    } occ_sw_state_t;
    typedef logic [2:0] occ_src_t;
endpackage

// File: logic/occ_trim_sel.sv
// trim selection by sequencer index
`timescale 1ns/1ps
`include "occ_map.svh"
module occ_trim_sel
    import occ_pkg::*;
#(
    parameter int NIB = 4
) (
    input wire logic [15:0] trim_word,
    input wire logic [15:0] trim2_word,
    input wire logic seq_en,
    input wire logic [2:0] index,
    output logic [NIB-1:0] trim
);
    logic [NIB-1:0] nib [0:7];
    // refuse nibble widths the register split cannot serve
    if (NIB != 4) begin : g_bad_nib
        $error("occ_trim_sel: nibble width must be 4");
    end
    // split both registers into eight nibbles
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_nib
            assign nib[g] = trim_word[g*NIB +: NIB];
            assign nib[g+4] = trim2_word[g*NIB +: NIB];
        end
    endgenerate
    // [R7] sequencer mux by index
    // [R8] base trim alone when off; [R11] [R13] [R15] index picks nibble
    always_comb begin
        if (seq_en) begin
            trim = nib[index];
        end else begin
            trim = nib[0];
        end
    end
endmodule

// File: test/occ_far_model.sv
// partner model: pwm sequence index and oscillator switch acknowledge
`timescale 1ns/1ps
module occ_far_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic switch_start,
    input wire logic [7:0] ack_delay,
    input wire logic [2:0] index_set,
    output logic [2:0] pwm_index,
    output logic switch_ack
);
    logic [7:0] wait_cnt;
    // ****************************************
    // pwm index and oscillator side
    // ****************************************
    // index leaves a clock edge like the real pwm roll output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_index <= 3'h0;
        end else begin
            pwm_index <= index_set;
        end
    end
    // one-cycle ack after ack_delay cycles, so prompt or slow answers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 8'h00;
            switch_ack <= 1'b0;
        end else if (!switch_start || switch_ack) begin
            wait_cnt <= 8'h00;
            switch_ack <= 1'b0;
        end else if (wait_cnt == ack_delay) begin
            switch_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule

// File: test/testbench.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
`include "occ_map.svh"
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pll_locked = 1'b0;
    logic clock_fail = 1'b0;
    logic switch_ack;
    logic [2:0] pwm_index;
    logic [2:0] requested_clock_source;
    logic switch_start;
    logic random_dither_enable;
    logic [3:0] frc_trim;
    logic irq;
    logic [7:0] ack_delay = 8'h14;
    logic [2:0] index_set = 3'h0;
    int n_start = 0;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    occ_ctrl #(.AW(12)) dut (
        .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .pll_locked, .clock_fail, .switch_ack, .pwm_index,
        .requested_clock_source, .switch_start, .random_dither_enable,
        .frc_trim, .irq
    );
    occ_far_model far (
        .hclk, .hresetn, .switch_start, .ack_delay, .index_set,
        .pwm_index, .switch_ack
    );

    // ****************************************
    // clock, watchdog and reporting
    // ****************************************
    always #4 hclk = ~hclk;
    // count cycles with a switch pending, for the redundant case
    always @(posedge hclk) begin
        if (switch_start === 1'b1) begin
            n_start <= n_start + 1;
        end
    end
    // cut a hang short
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // ****************************************
    // bus and stimulus helpers
    // ****************************************
    // one single ahb-lite transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // write, then one edge so the register has landed
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        @(posedge hclk);
    endtask
    task automatic rd(input string n, input logic [11:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(n, q, e);
    endtask
    // read control until the request bit reads zero
    task automatic poll_idle();
        logic [31:0] q;
        q = 32'h1;
        for (int k = 0; k < 80 && q[0] !== 1'b0; k++) begin
            bus(1'b0, `OCC_CTRL_OFS, 32'h0, q);
        end
    endtask
    task automatic wait_start();
        for (int k = 0; k < 40 && switch_start !== 1'b1; k++) begin
            @(posedge hclk);
        end
    endtask
    task automatic pulse_fail();
        clock_fail <= 1'b1;
        @(posedge hclk);
        clock_fail <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd("ctrl", `OCC_CTRL_OFS, 32'h0);
        rd("trim", `OCC_TRIM_OFS, 32'h0);
        rd("trim2", `OCC_TRIM2_OFS, 32'h0);
        check("frc_trim", 32'(frc_trim), 32'h0);
        check("hresp", 32'(hresp), 32'h0);
        check("hreadyout", 32'(hreadyout), 32'h1);
    endtask
    // every index with the sequencer off, then on
    task automatic t_trim();
        logic [3:0] e;
        wr(`OCC_TRIM_OFS, 32'h3218);
        wr(`OCC_TRIM2_OFS, 32'h7654);
        rd("trim", `OCC_TRIM_OFS, 32'h3218);
        for (int s = 0; s < 2; s++) begin
            wr(`OCC_CTRL_OFS, (s == 1) ? 32'h4 : 32'h0);
            for (int i = 0; i < 8; i++) begin
                index_set <= 3'(i);
                repeat (3) @(posedge hclk);
                e = (s == 0 || i == 0) ? 4'h8 : 4'(i);
                check("trim", 32'(frc_trim), 32'(e));
            end
        end
        wr(`OCC_CTRL_OFS, 32'h0);
    endtask
    task automatic t_dither();
        wr(`OCC_CTRL_OFS, 32'h10);
        check("dither", 32'(random_dither_enable), 32'h1);
        rd("ctrl", `OCC_CTRL_OFS, 32'h10);
        wr(`OCC_CTRL_OFS, 32'h0);
        check("dither", 32'(random_dither_enable), 32'h0);
        // a write with the clock enable low must not land
        clk_en <= 1'b0;
        wr(`OCC_CTRL_OFS, 32'h10);
        clk_en <= 1'b1;
        check("frozen", 32'(random_dither_enable), 32'h0);
    endtask
    // slow switch, lock flag, redundant switch, lock masking
    task automatic t_switch();
        int s0;
        wr(`OCC_CTRL_OFS, 32'h301);
        wait_start();
        check("start", 32'(switch_start), 32'h1);
        check("req", 32'(requested_clock_source), 32'h3);
        rd("ctrl", `OCC_CTRL_OFS, 32'h301);
        poll_idle();
        rd("ctrl", `OCC_CTRL_OFS, 32'h3300);
        pll_locked <= 1'b1;
        repeat (3) @(posedge hclk);
        rd("ctrl", `OCC_CTRL_OFS, 32'h3320);
        pll_locked <= 1'b0;
        rd("ctrl", `OCC_CTRL_OFS, 32'h3300);
        s0 = n_start;
        wr(`OCC_CTRL_OFS, 32'h301);
        poll_idle();
        check("redundant", 32'(n_start - s0), 32'h0);
        pll_locked <= 1'b1;
        wr(`OCC_CTRL_OFS, 32'h201);
        poll_idle();
        rd("ctrl", `OCC_CTRL_OFS, 32'h2200);
        wr(`OCC_CTRL_OFS, 32'h301);
        poll_idle();
        rd("ctrl", `OCC_CTRL_OFS, 32'h3300);
        pll_locked <= 1'b0;
    endtask
    // failure flag, interrupt mask and clear, failover mid-switch
    task automatic t_fail();
        rd("status", `OCC_IRQ_STAT_OFS, 32'h6);
        wr(`OCC_IRQ_EN_OFS, 32'h1);
        check("irq", 32'(irq), 32'h0);
        wr(`OCC_IRQ_CLR_OFS, 32'h6);
        rd("status", `OCC_IRQ_STAT_OFS, 32'h0);
        // failover drops the active source back to fast rc
        pulse_fail();
        check("irq", 32'(irq), 32'h1);
        rd("ctrl", `OCC_CTRL_OFS, 32'h308);
        wr(`OCC_IRQ_CLR_OFS, 32'h1);
        check("irq", 32'(irq), 32'h0);
        rd("ctrl", `OCC_CTRL_OFS, 32'h308);
        wr(`OCC_CTRL_OFS, 32'h300);
        rd("ctrl", `OCC_CTRL_OFS, 32'h300);
        pulse_fail();
        ack_delay <= 8'hff;
        wr(`OCC_CTRL_OFS, 32'h209);
        wait_start();
        rd("ctrl", `OCC_CTRL_OFS, 32'h201);
        pulse_fail();
        check("start", 32'(switch_start), 32'h0);
        rd("ctrl", `OCC_CTRL_OFS, 32'h208);
        wr(`OCC_CTRL_OFS, 32'h7200);
        rd("ctrl", `OCC_CTRL_OFS, 32'h200);
        rd("unmapped", 12'h020, 32'h0);
        rd("clear", `OCC_IRQ_CLR_OFS, 32'h0);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_trim();
        t_dither();
        t_switch();
        t_fail();
        report_and_stop();
    end
endmodule
